// >>> src/ccr_pkg.sv
// Package: register map, field layout and enumerations of the control core
package ccr_pkg;
  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] CCR_OFF_CORE = 8'h00;
  localparam logic [7:0] CCR_OFF_IRQ = 8'h04;
  localparam logic [7:0] CCR_OFF_MASK = 8'h08;
  localparam logic [7:0] CCR_OFF_TXPEND = 8'h0c;
  localparam logic [7:0] CCR_OFF_TXREQ = 8'h10;
  localparam logic [7:0] CCR_OFF_TXCANCEL = 8'h14;
  localparam logic [7:0] CCR_OFF_EVENT = 8'h18;
  localparam logic [7:0] CCR_OFF_ID = 8'h1c;
  // Core control register fields
  localparam int CCR_B_INIT = 0;
  localparam int CCR_B_CCE = 1;
  localparam int CCR_B_ROM = 2;
  localparam int CCR_B_CSA = 3;
  localparam int CCR_B_CSR = 4;
  localparam int CCR_B_CMR_LO = 8;
  localparam int CCR_B_FMT_LO = 10;
  // Interrupt flag fields
  localparam int CCR_B_RAF = 0;
  localparam int CCR_B_TXDONE = 1;
  localparam int CCR_B_EVLOST = 2;
  localparam int CCR_NIRQ = 3;
  // Event register fields
  localparam int CCR_B_EV_EDL = 0;
  localparam int CCR_B_EV_BRS = 1;
  localparam int CCR_B_EV_VLD = 2;
  localparam int CCR_B_EV_BUF = 8;
  localparam int CCR_NBUF = 32;
  localparam int CCR_EV_DEPTH = 8;
  // Arbitrary identification value, not tied to any part
  localparam logic [31:0] CCR_ID_VALUE = 32'h0c0d_0001;
  // Frame format modes
  typedef enum logic [1:0] {
    CCR_FMT_CLASSIC = 2'h0,
    CCR_FMT_FD = 2'h1,
    CCR_FMT_FD_BRS = 2'h2
  } ccr_fmt_t;
  // Transmit sequencer states, gray along idle-load-send-store
  typedef enum logic [1:0] {
    CCR_TX_IDLE = 2'h0,
    CCR_TX_LOAD = 2'h1,
    CCR_TX_SEND = 2'h3,
    CCR_TX_STORE = 2'h2
  } ccr_txst_t;
endpackage : ccr_pkg

// >>> src/ccr_event_mem.sv
// Transmit event memory: small register file, registered read data
module ccr_event_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:7];

  // Storage and registered read; no reset keeps it a plain memory
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : ccr_event_mem

// >>> src/ccr_core.sv
// Control core: restricted mode, clock stop, mode request, tx events
// Operation
// - RAM access failure in transmission sets flag and restricted mode bit
// - On clock stop the core sets init and acknowledge bits
// - First frame after restricted mode uses freshly loaded id/control
// - Mode request selects classic, FD, or FD with rate switching
// - Event entry format bits match the format actually sent
// - Init during reception gives no spurious access failure flag
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module ccr_core
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core status pins
  input wire logic ram_fail_in,
  input wire logic rx_active_in,
  input wire logic tx_done_in,
  output logic tx_start,
  output ccr_pkg::ccr_fmt_t tx_fmt,
  output logic [4:0] tx_buf,
  output logic irq
);
  import ccr_pkg::*;

  // Registers
  logic init_r, cce_r, rom_r, csa_r, csr_r;
  ccr_fmt_t cmr_r, fmt_r;
  logic [CCR_NIRQ-1:0] irq_flag_r, mask_r;
  logic [31:0] pend_r;
  ccr_txst_t st_r;
  logic [4:0] buf_r;
  logic [3:0] ev_cnt_r;
  logic [2:0] ev_wp_r, ev_rp_r;
  logic rd_evt_r;
  logic [31:0] prdata_nxt;
  logic ram_fail_s1, ram_fail_s2, rx_act_s1, rx_act_s2, txd_s1, txd_s2;
  logic [7:0] ev_rd;

  // Pins come from outside the clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ram_fail_s1, ram_fail_s2} <= 2'h0;
      {rx_act_s1, rx_act_s2} <= 2'h0;
      {txd_s1, txd_s2} <= 2'h0;
    end else begin
      ram_fail_s1 <= ram_fail_in;
      ram_fail_s2 <= ram_fail_s1;
      rx_act_s1 <= rx_active_in;
      rx_act_s2 <= rx_act_s1;
      txd_s1 <= tx_done_in;
      txd_s2 <= txd_s1;
    end
  end

  // Lowest pending buffer index
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = CCR_NBUF - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[4:0];
      end
    end
    return r;
  endfunction : first_set

  // Bus decode; an access acts once, in the cycle before pready rises,
  // so a read-clear or a pop is never applied twice by one transfer
  wire acc = psel && penable && !pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire wr_core = wr && (paddr == CCR_OFF_CORE);
  wire wr_mask = wr && (paddr == CCR_OFF_MASK);
  wire wr_req = wr && (paddr == CCR_OFF_TXREQ);
  wire wr_can = wr && (paddr == CCR_OFF_TXCANCEL);
  wire rd_irq = rd && (paddr == CCR_OFF_IRQ);
  wire rd_ev = rd && (paddr == CCR_OFF_EVENT);
  wire mapped = (paddr == CCR_OFF_CORE) || (paddr == CCR_OFF_IRQ) ||
    (paddr == CCR_OFF_MASK) || (paddr == CCR_OFF_TXPEND) ||
    (paddr == CCR_OFF_TXREQ) || (paddr == CCR_OFF_TXCANCEL) ||
    (paddr == CCR_OFF_EVENT) || (paddr == CCR_OFF_ID);
  wire idle = (st_r == CCR_TX_IDLE);
  wire stopping = csr_r && idle && !rx_act_s2;
  wire ev_full = (ev_cnt_r == 4'(CCR_EV_DEPTH));
  // failure only counts while a frame is on its way out
  wire raf_evt = ram_fail_s2 && (st_r == CCR_TX_SEND);
  wire done_evt = txd_s2 && (st_r == CCR_TX_SEND);
  wire go = !init_r && !rom_r && !csr_r && (pend_r != 32'h0);
  wire [CCR_NIRQ-1:0] irq_set = {done_evt && ev_full, done_evt, raf_evt};
  wire [1:0] cmr_w = pwdata[CCR_B_CMR_LO +: 2];

  // Core control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_r <= 1'b1;
      {cce_r, rom_r, csa_r, csr_r} <= 4'h0;
      cmr_r <= CCR_FMT_CLASSIC;
    end else begin
      if (wr_core) begin
        // combined write accepted in one step
        csr_r <= pwdata[CCR_B_CSR];
        cce_r <= pwdata[CCR_B_INIT] && pwdata[CCR_B_CCE];
        if (!pwdata[CCR_B_ROM]) begin
          rom_r <= 1'b0;
        end
        // Clearing init needs the stop request dropped, earlier or in the same write
        init_r <= pwdata[CCR_B_INIT] || (csr_r && pwdata[CCR_B_CSR]);
        if (!pwdata[CCR_B_CSR]) begin
          csa_r <= 1'b0;
        end
        // mode request written while running or configuring
        if (cmr_w != 2'h3) begin
          cmr_r <= ccr_fmt_t'(cmr_w);
        end
      end
      // stop in effect: init and acknowledge both set
      if (stopping && !(wr_core && !pwdata[CCR_B_CSR])) begin
        init_r <= 1'b1;
        csa_r <= 1'b1;
      end
      // hardware set wins over a concurrent software clear
      if (raf_evt) begin
        rom_r <= 1'b1;
      end
    end
  end

  // Interrupt flags and mask; read clears, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_flag_r <= '0;
      mask_r <= '0;
    end else begin
      irq_flag_r <= (rd_irq ? '0 : irq_flag_r) | irq_set;
      if (wr_mask) begin
        mask_r <= pwdata[CCR_NIRQ-1:0];
      end
    end
  end

  // Pending set: request adds, cancel and completion remove
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~(wr_can ? pwdata : 32'h0) &
        ~((done_evt ? 32'h1 : 32'h0) << buf_r)) |
        (wr_req ? pwdata : 32'h0);
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= CCR_TX_IDLE;
      buf_r <= 5'h00;
      fmt_r <= CCR_FMT_CLASSIC;
    end else begin
      case (st_r)
        CCR_TX_IDLE: begin
          if (go) begin
            st_r <= CCR_TX_LOAD;
          end
        end
        CCR_TX_LOAD: begin
          // id and control reloaded from the pending buffer each start
          buf_r <= first_set(pend_r);
          // format latched once, so later mode writes cannot skew it
          fmt_r <= cmr_r;
          st_r <= CCR_TX_SEND;
        end
        CCR_TX_SEND: begin
          if (raf_evt) begin
            st_r <= CCR_TX_IDLE;
          end else if (done_evt) begin
            st_r <= CCR_TX_STORE;
          end
        end
        CCR_TX_STORE: begin
          st_r <= CCR_TX_IDLE;
        end
        default: begin
          st_r <= CCR_TX_IDLE;
        end
      endcase
    end
  end

  // Event queue pointers; a full queue drops the entry and flags it
  wire ev_push = done_evt && !ev_full;
  wire ev_pop = rd_ev && (ev_cnt_r != 4'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_wp_r <= 3'h0;
      ev_rp_r <= 3'h0;
      ev_cnt_r <= 4'h0;
      rd_evt_r <= 1'b0;
    end else begin
      ev_wp_r <= ev_wp_r + 3'(ev_push);
      ev_rp_r <= ev_rp_r + 3'(ev_pop);
      ev_cnt_r <= ev_cnt_r + 4'(ev_push) - 4'(ev_pop);
      rd_evt_r <= ev_cnt_r != 4'h0;
    end
  end

  // stored format bits come from the latched sent format
  wire [7:0] ev_wdata = {1'b0, buf_r, fmt_r == CCR_FMT_FD_BRS,
    fmt_r != CCR_FMT_CLASSIC};
  ccr_event_mem u_ev (
    .clk(clk),
    .wr_en(ev_push),
    .wr_addr(ev_wp_r),
    .wr_data(ev_wdata),
    .rd_addr(ev_rp_r),
    .rd_data(ev_rd)
  );

  // Read mux
  always_comb begin
    prdata_nxt = 32'h0;
    case (paddr)
      CCR_OFF_CORE: begin
        prdata_nxt[CCR_B_INIT] = init_r;
        prdata_nxt[CCR_B_CCE] = cce_r;
        prdata_nxt[CCR_B_ROM] = rom_r;
        prdata_nxt[CCR_B_CSA] = csa_r;
        prdata_nxt[CCR_B_CSR] = csr_r;
        prdata_nxt[CCR_B_CMR_LO +: 2] = cmr_r;
        prdata_nxt[CCR_B_FMT_LO +: 2] = fmt_r;
      end
      CCR_OFF_IRQ: prdata_nxt[CCR_NIRQ-1:0] = irq_flag_r;
      CCR_OFF_MASK: prdata_nxt[CCR_NIRQ-1:0] = mask_r;
      CCR_OFF_TXPEND: prdata_nxt = pend_r;
      CCR_OFF_EVENT: begin
        prdata_nxt[CCR_B_EV_EDL] = ev_rd[0];
        prdata_nxt[CCR_B_EV_BRS] = ev_rd[1];
        prdata_nxt[CCR_B_EV_VLD] = rd_evt_r;
        prdata_nxt[CCR_B_EV_BUF +: 5] = ev_rd[6:2];
      end
      CCR_OFF_ID: prdata_nxt = CCR_ID_VALUE;
      default: prdata_nxt = 32'h0;
    endcase
  end

  // Registered bus answer: one wait state, pready in second access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      prdata <= prdata_nxt;
      pslverr <= acc && !mapped;
    end
  end

  // Outputs from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_start <= 1'b0;
      tx_fmt <= CCR_FMT_CLASSIC;
      tx_buf <= 5'h00;
      irq <= 1'b0;
    end else begin
      tx_start <= (st_r == CCR_TX_LOAD);
      tx_fmt <= (st_r == CCR_TX_LOAD) ? cmr_r : fmt_r;
      tx_buf <= (st_r == CCR_TX_LOAD) ? first_set(pend_r) : buf_r;
      irq <= |((irq_flag_r | irq_set) & mask_r);
    end
  end

  // Assertions
  AST_RAF_SETS_ROM: assert property (@(posedge clk) disable iff (rst)
    raf_evt |=> rom_r && irq_flag_r[CCR_B_RAF])
    else $error("access failure did not enter restricted mode");
  AST_STOP_ACK: assert property (@(posedge clk) disable iff (rst)
    stopping && !wr_core |=> init_r && csa_r)
    else $error("clock stop not acknowledged");
  AST_FMT_LATCH: assert property (@(posedge clk) disable iff (rst)
    st_r == CCR_TX_LOAD |=> fmt_r == $past(cmr_r))
    else $error("format not taken from mode request");
  AST_FMT_STABLE: assert property (@(posedge clk) disable iff (rst)
    st_r == CCR_TX_SEND && $past(st_r) == CCR_TX_SEND |->
    $stable(fmt_r))
    else $error("format changed during transmission");
  AST_START_MATCH: assert property (@(posedge clk) disable iff (rst)
    tx_start |-> tx_buf == buf_r && tx_fmt == fmt_r)
    else $error("started frame differs from recorded buffer or format");
  AST_NO_TX_ROM: assert property (@(posedge clk) disable iff (rst)
    rom_r |-> !go)
    else $error("transmission started in restricted mode");
  AST_NO_RX_RAF: assert property (@(posedge clk) disable iff (rst)
    st_r != CCR_TX_SEND |=> !irq_flag_r[CCR_B_RAF] ||
    $past(irq_flag_r[CCR_B_RAF]))
    else $error("spurious access failure flag");
  AST_COMBINED_WR: assert property (@(posedge clk) disable iff (rst)
    wr_core && init_r && pwdata[CCR_B_INIT] && pwdata[CCR_B_CCE] &&
    !pwdata[CCR_B_CSR] && !pwdata[CCR_B_ROM] && !raf_evt |=>
    cce_r && !csr_r && !rom_r)
    else $error("combined write not accepted");
endmodule : ccr_core

// >>> tb/ccr_can_node.sv
// Far-side model: node and frame timer answering frames the core starts
module ccr_can_node #(
  parameter int DELAY = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame start and bench commands
  input wire logic tx_start,
  input wire logic fail_cmd,
  input wire logic rx_cmd,
  // Status pins toward the core
  output logic ram_fail_in,
  output logic rx_active_in,
  output logic tx_done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Frame timer; a commanded failure lands well inside the frame,
  // or anywhere while a reception is under way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      ram_fail_in <= 1'b0;
      tx_done_in <= 1'b0;
    end else begin
      if (tx_start) begin
        cnt <= DELAY + 4;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      ram_fail_in <= fail_cmd && (rx_cmd || (cnt > 3 && cnt < 7));
      tx_done_in <= cnt == 1;
    end
  end
  // Reception window follows the bench command only
  assign rx_active_in = rx_cmd;
endmodule : ccr_can_node

// >>> tb/tb.sv
// Testbench: APB sequences for modes, failure and restricted-mode recovery
module tb;
  import ccr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic ram_fail_in, rx_active_in, tx_done_in, tx_start, fail_cmd, rx_cmd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] tx_buf, seen_buf;
  ccr_fmt_t tx_fmt, seen_fmt;
  int bad_count, checks_done;
  int cycles = 0;

  ccr_core i_ccr_core (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ram_fail_in(ram_fail_in),
    .rx_active_in(rx_active_in), .tx_done_in(tx_done_in),
    .tx_start(tx_start), .tx_fmt(tx_fmt), .tx_buf(tx_buf), .irq(irq));
  ccr_can_node i_ccr_can_node (.clk(clk), .rst(rst), .tx_start(tx_start),
    .fail_cmd(fail_cmd), .rx_cmd(rx_cmd), .ram_fail_in(ram_fail_in),
    .rx_active_in(rx_active_in), .tx_done_in(tx_done_in));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Format and buffer of the frame as it starts
  always @(posedge clk) begin
    if (tx_start === 1'b1) begin
      seen_fmt <= tx_fmt;
      seen_buf <= tx_buf;
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is taken at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd & m, exp);
  endtask : rdchk

  // Bounded polling: status bits may take a few cycles through synchronisers
  task automatic poll(input logic [7:0] a, input logic [31:0] m, exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== exp && n < 40);
    chk("poll", rd & m, exp);
  endtask : poll

  // Send from one buffer, then compare start format and event entry
  task automatic frame(input int b, input logic [1:0] f);
    apb(1'b1, CCR_OFF_TXREQ, 32'h1 << b);
    poll(CCR_OFF_IRQ, 32'h2, 32'h2);
    chk("fmt", 32'(seen_fmt), 32'(f));
    chk("buf", 32'(seen_buf), 32'(b));
    rdchk("event", CCR_OFF_EVENT, 32'h1f07,
      {19'h0, 5'(b), 5'h0, 1'b1, f == 2'h2, f != 2'h0});
  endtask : frame

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, fail_cmd, rx_cmd} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk("core", CCR_OFF_CORE, 32'hffffffff, 32'h1);
    rdchk("id", CCR_OFF_ID, 32'hffffffff, CCR_ID_VALUE);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    apb(1'b1, CCR_OFF_MASK, 32'h1);
    // Each mode, mode changed only with nothing pending
    for (int m = 0; m < 3; m++) begin
      poll(CCR_OFF_TXPEND, 32'hffffffff, 32'h0);
      apb(1'b1, CCR_OFF_CORE, 32'(m) << CCR_B_CMR_LO);
      frame(m, 2'(m));
    end
    // Failure in mid-frame
    fail_cmd <= 1'b1;
    apb(1'b1, CCR_OFF_TXREQ, 32'h8);
    poll(CCR_OFF_CORE, 32'h4, 32'h4);
    chk("irq", 32'(irq), 32'h1);
    rdchk("raf", CCR_OFF_IRQ, 32'h1, 32'h1);
    fail_cmd <= 1'b0;
    repeat (3) @(negedge clk);
    chk("irq clear", 32'(irq), 32'h0);
    // Recovery; reception holds off the first stop acknowledge
    apb(1'b1, CCR_OFF_TXCANCEL, 32'hffffffff);
    poll(CCR_OFF_TXPEND, 32'hffffffff, 32'h0);
    rx_cmd <= 1'b1;
    apb(1'b1, CCR_OFF_CORE, 32'h14);
    rdchk("ack held", CCR_OFF_CORE, 32'h8, 32'h0);
    rx_cmd <= 1'b0;
    poll(CCR_OFF_CORE, 32'h9, 32'h9);
    apb(1'b1, CCR_OFF_CORE, 32'h5);
    rdchk("ack drop", CCR_OFF_CORE, 32'h8, 32'h0);
    apb(1'b1, CCR_OFF_CORE, 32'h4);
    poll(CCR_OFF_CORE, 32'h1, 32'h0);
    apb(1'b1, CCR_OFF_CORE, 32'h14);
    poll(CCR_OFF_CORE, 32'h9, 32'h9);
    apb(1'b1, CCR_OFF_CORE, 32'h3);
    rdchk("combined", CCR_OFF_CORE, 32'h1f, 32'h3);
    apb(1'b1, CCR_OFF_CORE, 32'h0);
    poll(CCR_OFF_CORE, 32'h1, 32'h0);
    apb(1'b1, CCR_OFF_CORE, 32'h200);
    frame(3, 2'h2);
    // Init set and cleared during reception, with the failure pin raised
    rx_cmd <= 1'b1;
    fail_cmd <= 1'b1;
    apb(1'b1, CCR_OFF_CORE, 32'h201);
    apb(1'b1, CCR_OFF_CORE, 32'h200);
    rx_cmd <= 1'b0;
    fail_cmd <= 1'b0;
    rdchk("no raf", CCR_OFF_IRQ, 32'h1, 32'h0);
    frame(4, 2'h2);
    // Reserved mode code leaves the mode request as it was
    apb(1'b1, CCR_OFF_CORE, 32'h300);
    rdchk("cmr keep", CCR_OFF_CORE, 32'h300, 32'h200);
    test_done();
  end
endmodule : tb
